// >>> verilog/mode_pin_control.sv
// What this block does
// - while processing enable is high the five correction and detection features are enabled.
// - software may turn off single features through the feature disable register and the block obeys each bit.
// - while processing enable is low the block selects low-latency mode.
// - with the test select pin high the four shared pins serve the boundary-scan port.
// - with the test select pin low the four shared pins serve the serial host port.
// - in host mode a low reset pin returns all functional blocks to their defaults.
// - in host mode a low reset pin releases every output except status and error summary.
// - during host-mode reset the status and error summary outputs hold their last value.
// - in test mode a low reset pin defaults all blocks and holds the scan sequence in reset.
// - in test mode a high reset pin lets the scan sequence run.
// - in host mode the shared select pin is an active-low chip select.
// - in test mode the shared select pin is the active-high scan mode select.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mode_pin_consts.svh"
module mode_pin_control #(
  parameter int DATA_WIDTH = 10,
  parameter int STATUS_WIDTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic processing_enable_pin,
  input wire logic test_select_pin,
  input wire logic reset_pin_n,
  input wire logic shared_select_pin,
  input wire logic shared_clock_pin,
  input wire logic shared_serial_in_pin,
  output logic shared_serial_out_pin,
  output logic shared_serial_out_pin_oe_n,
  output logic host_select_n,
  output logic host_clock,
  output logic host_serial_in,
  input wire logic host_serial_out,
  input wire logic host_serial_out_en,
  output logic scan_mode_select,
  output logic scan_clock,
  output logic scan_data_in,
  input wire logic scan_data_out,
  input wire logic scan_data_out_en,
  output var logic scan_reset_n,
  output var logic [`NUM_FEATURES-1:0] feature_enable,
  output var logic low_latency_mode,
  output var logic functional_reset_n,
  input wire logic [DATA_WIDTH-1:0] core_data,
  input wire logic [STATUS_WIDTH-1:0] core_status,
  input wire logic core_error_n,
  output var logic [DATA_WIDTH-1:0] data_out,
  output var logic data_out_oe_n,
  output logic [STATUS_WIDTH-1:0] status_out,
  output logic error_out_n
);
  logic [`PIN_COUNT-1:0] pins_s;
  logic proc_en;
  logic test_mode;
  logic reset_low;
  logic host_in_reset;
  logic [`NUM_FEATURES-1:0] feature_disable;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [3:0] ar_addr_word;
  logic [3:0] aw_addr_word;
  logic [2:0] settle_cnt;
  logic settled;
  mode_pin_pkg::wr_state_t wr_state;
  mode_pin_pkg::rd_state_t rd_state;

  // ----------------------------------------
  // pin synchronisation
  // ----------------------------------------
  // shared pins are synchronised too: the host and scan engines run on aclk
  pin_sync #(
    .WIDTH(`PIN_COUNT),
    .RESET_VALUE(`PIN_SYNC_RESET)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins({processing_enable_pin, test_select_pin, reset_pin_n,
           shared_select_pin, shared_clock_pin, shared_serial_in_pin}),
    .synced(pins_s)
  );

  // decoded modes, all from synchronised levels
  assign proc_en = pins_s[`PIN_PROC_EN];
  assign test_mode = pins_s[`PIN_TEST_SEL];
  assign reset_low = !pins_s[`PIN_RESET_N];
  assign host_in_reset = reset_low && !test_mode;

  // ----------------------------------------
  // shared pin routing
  // ----------------------------------------
  // idle levels keep the unselected engine quiet
  assign host_select_n = test_mode ? 1'b1 : pins_s[`PIN_SELECT];
  assign host_clock = test_mode ? 1'b0 : pins_s[`PIN_CLOCK];
  assign host_serial_in = test_mode ? 1'b0 : pins_s[`PIN_SER_IN];
  assign scan_mode_select = test_mode ? pins_s[`PIN_SELECT] : 1'b0;
  assign scan_clock = test_mode ? pins_s[`PIN_CLOCK] : 1'b0;
  assign scan_data_in = test_mode ? pins_s[`PIN_SER_IN] : 1'b0;

  // serial out follows the selected engine; released in host-mode reset
  assign shared_serial_out_pin = test_mode ? scan_data_out : host_serial_out;
  assign shared_serial_out_pin_oe_n = host_in_reset ||
                                      !(test_mode ? scan_data_out_en : host_serial_out_en);

  // ----------------------------------------
  // mode and reset outputs
  // ----------------------------------------
  // registered so the core sees glitch-free levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      functional_reset_n <= 1'b0;
      scan_reset_n <= 1'b0;
      low_latency_mode <= 1'b0;
      feature_enable <= '0;
    end else begin
      functional_reset_n <= !reset_low;
      scan_reset_n <= !(test_mode && reset_low);
      low_latency_mode <= !proc_en;
      feature_enable <= {`NUM_FEATURES{proc_en}} & ~feature_disable;
    end
  end

  // ----------------------------------------
  // output release and status hold
  // ----------------------------------------
  // data drivers go quiet during host-mode reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_out <= '0;
      data_out_oe_n <= 1'b1;
    end else begin
      data_out <= core_data;
      data_out_oe_n <= host_in_reset;
    end
  end

  // status and error summary freeze instead of floating
  output_hold #(
    .WIDTH(STATUS_WIDTH + 1)
  ) u_output_hold (
    .aclk(aclk),
    .aresetn(aresetn),
    .hold(host_in_reset),
    .live({core_status, core_error_n}),
    .held({status_out, error_out_n})
  );

  // ----------------------------------------
  // bus write channel
  // ----------------------------------------
  assign s_axi_awready = (wr_state == mode_pin_pkg::WR_IDLE) && !aw_held;
  assign s_axi_wready = (wr_state == mode_pin_pkg::WR_IDLE) && !w_held;
  assign aw_addr_word = {aw_addr[3:2], 2'b00};

  // address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wr_state == mode_pin_pkg::WR_RESP) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= mode_pin_pkg::WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      case (wr_state)
        mode_pin_pkg::WR_IDLE: begin
          if (aw_held && w_held) begin
            wr_state <= mode_pin_pkg::WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_word == `FEATURE_DISABLE_OFFSET ||
                            aw_addr_word == `MODE_STATUS_OFFSET) ? `RESP_OKAY : `RESP_DECERR;
          end
        end
        mode_pin_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wr_state <= mode_pin_pkg::WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state <= mode_pin_pkg::WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // feature disable bits; functional reset wins over a software write
  always_ff @(posedge aclk) begin
    if (!aresetn || reset_low) begin
      feature_disable <= `FEATURE_DISABLE_RESET;
    end else if (wr_state == mode_pin_pkg::WR_IDLE && aw_held && w_held &&
                 aw_addr_word == `FEATURE_DISABLE_OFFSET && w_strb[0]) begin
      feature_disable <= w_data[`NUM_FEATURES-1:0];
    end
  end

  // ----------------------------------------
  // bus read channel
  // ----------------------------------------
  assign s_axi_arready = (rd_state == mode_pin_pkg::RD_IDLE);
  assign ar_addr_word = {s_axi_araddr[3:2], 2'b00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= mode_pin_pkg::RD_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      case (rd_state)
        mode_pin_pkg::RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state <= mode_pin_pkg::RD_DATA;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            if (ar_addr_word == `FEATURE_DISABLE_OFFSET) begin
              s_axi_rdata[`NUM_FEATURES-1:0] <= feature_disable;
            end else if (ar_addr_word == `MODE_STATUS_OFFSET) begin
              s_axi_rdata[`STAT_PROC_ENABLE] <= proc_en;
              s_axi_rdata[`STAT_TEST_MODE] <= test_mode;
              s_axi_rdata[`STAT_RESET_PIN] <= !reset_low;
              s_axi_rdata[`STAT_LOW_LATENCY] <= low_latency_mode;
            end else begin
              s_axi_rresp <= `RESP_DECERR;
            end
          end
        end
        mode_pin_pkg::RD_DATA: begin
          if (s_axi_rready) begin
            rd_state <= mode_pin_pkg::RD_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: begin
          rd_state <= mode_pin_pkg::RD_IDLE;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // settle counter hides the synchroniser fill after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt <= 3'h0;
    end else if (settle_cnt != `SETTLE_CYCLES) begin
      settle_cnt <= settle_cnt + 3'h1;
    end
  end
  assign settled = (settle_cnt == `SETTLE_CYCLES);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_feature_group: assert property (settled && $past(processing_enable_pin, 3) |->
      feature_enable == ~$past(feature_disable)) else $error("features not enabled by pin");
  a_feature_mask: assert property (settled |-> (feature_enable & $past(feature_disable)) == '0)
    else $error("disabled feature still on");
  a_low_latency: assert property (settled |-> low_latency_mode == !$past(processing_enable_pin, 3))
    else $error("low latency mode wrong");
  a_scan_routing: assert property (settled && $past(test_select_pin, 2) |->
      scan_clock == $past(shared_clock_pin, 2) && host_select_n) else $error("scan routing wrong");
  a_host_routing: assert property (settled && !$past(test_select_pin, 2) |->
      host_serial_in == $past(shared_serial_in_pin, 2) && !scan_clock) else $error("host routing wrong");
  a_block_reset: assert property (settled && !$past(reset_pin_n, 3) |-> !functional_reset_n)
    else $error("functional reset missing");
  a_outputs_released: assert property (host_in_reset |-> shared_serial_out_pin_oe_n ##1 data_out_oe_n)
    else $error("drivers active in reset");
  a_status_frozen: assert property (host_in_reset ##1 host_in_reset |->
      $stable(status_out) && $stable(error_out_n)) else $error("status moved in reset");
  a_scan_held: assert property (settled && $past(test_select_pin, 3) && !$past(reset_pin_n, 3) |->
      !scan_reset_n) else $error("scan not held in reset");
  a_scan_resume: assert property (settled && $past(reset_pin_n, 3) |-> scan_reset_n)
    else $error("scan reset stuck");
  a_select_levels: assert property (settled && $past(test_select_pin, 2) |->
      scan_mode_select == $past(shared_select_pin, 2)) else $error("scan select wrong");
endmodule // mode_pin_control
`default_nettype wire

// >>> verilog/mode_pin_consts.svh
`ifndef MODE_PIN_CONSTS_SVH
`define MODE_PIN_CONSTS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define FEATURE_DISABLE_OFFSET 4'h0
`define MODE_STATUS_OFFSET 4'h4
`define FEATURE_DISABLE_RESET 5'h00

// ----------------------------------------
// feature bit positions
// ----------------------------------------
`define NUM_FEATURES 5
`define FEAT_ILLEGAL_REMAP 0
`define FEAT_EDH_CRC_FIX 1
`define FEAT_ANC_CSUM_FIX 2
`define FEAT_TRS_FIX 3
`define FEAT_EDH_FLAGS 4

// ----------------------------------------
// mode status fields
// ----------------------------------------
`define STAT_PROC_ENABLE 0
`define STAT_TEST_MODE 1
`define STAT_RESET_PIN 2
`define STAT_LOW_LATENCY 3

// ----------------------------------------
// pin synchroniser layout and reset value
// ----------------------------------------
`define PIN_COUNT 6
`define PIN_PROC_EN 5
`define PIN_TEST_SEL 4
`define PIN_RESET_N 3
`define PIN_SELECT 2
`define PIN_CLOCK 1
`define PIN_SER_IN 0
`define PIN_SYNC_RESET 6'h04

// ----------------------------------------
// bus responses and settle time
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`define SETTLE_CYCLES 3'h4

`endif

// >>> verilog/mode_pin_pkg.sv
`default_nettype none
package mode_pin_pkg;
  typedef enum logic [0:0] {WR_IDLE = 1'b0, WR_RESP = 1'b1} wr_state_t;
  typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_DATA = 1'b1} rd_state_t;
endpackage
`default_nettype wire

// >>> verilog/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pins,
  output var logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage1;

  // ----------------------------------------
  // two-flop synchroniser, first stage feeds only the second
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= RESET_VALUE;
      synced <= RESET_VALUE;
    end else begin
      stage1 <= pins;
      synced <= stage1;
    end
  end
endmodule // pin_sync
`default_nettype wire

// >>> verilog/output_hold.sv
`timescale 1ns/1ps
`default_nettype none
module output_hold #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hold,
  input wire logic [WIDTH-1:0] live,
  output var logic [WIDTH-1:0] held
);
  // ----------------------------------------
  // follows live values, freezes while hold is high
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          held[i] <= 1'b0;
        end else if (!hold) begin
          held[i] <= live[i];
        end
      end
    end
  endgenerate
endmodule // output_hold
`default_nettype wire

// >>> verif/board_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module board_ctrl (
  input wire logic aclk,
  input wire logic want_proc,
  input wire logic want_test,
  input wire logic want_rst_n,
  input wire logic want_sel,
  input wire logic want_clk,
  input wire logic want_sdi,
  input wire logic buffer_video_mode,
  output var logic processing_enable_pin,
  output var logic test_select_pin,
  output var logic reset_pin_n,
  output var logic shared_select_pin,
  output var logic shared_clock_pin,
  output var logic shared_serial_in_pin
);
  // ----------------------------------------
  // static strap and control drivers
  // ----------------------------------------
  // a buffer in video or extraction mode forces processing on, whatever was asked
  always_ff @(posedge aclk) begin
    processing_enable_pin <= want_proc | buffer_video_mode;
    test_select_pin <= want_test;
    reset_pin_n <= want_rst_n;
    shared_select_pin <= want_sel;
    shared_clock_pin <= want_clk;
    shared_serial_in_pin <= want_sdi;
  end
endmodule // board_ctrl
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mode_pin_consts.svh"
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic host_serial_out = 1'b0, host_serial_out_en = 1'b0, scan_data_out = 1'b0, scan_data_out_en = 1'b0;
  logic [9:0] core_data = 10'h000;
  logic [3:0] core_status = 4'h0;
  logic core_error_n = 1'b1;
  logic want_proc = 1'b0, want_test = 1'b0, want_rst_n = 1'b1, want_sel = 1'b1, want_clk = 1'b0, want_sdi = 1'b0;
  logic buffer_video_mode = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic processing_enable_pin, test_select_pin, reset_pin_n, shared_select_pin, shared_clock_pin, shared_serial_in_pin;
  logic shared_serial_out_pin, shared_serial_out_pin_oe_n, host_select_n, host_clock, host_serial_in;
  logic scan_mode_select, scan_clock, scan_data_in, scan_reset_n, low_latency_mode, functional_reset_n;
  logic [4:0] feature_enable;
  logic [9:0] data_out;
  logic data_out_oe_n, error_out_n;
  logic [3:0] status_out;
  int n_errors = 0;
  int n_checks = 0;
  int i;

  always #5 aclk = ~aclk;

  board_ctrl partner (.aclk, .want_proc, .want_test, .want_rst_n, .want_sel, .want_clk, .want_sdi,
    .buffer_video_mode, .processing_enable_pin, .test_select_pin, .reset_pin_n, .shared_select_pin,
    .shared_clock_pin, .shared_serial_in_pin);

  mode_pin_control uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .processing_enable_pin, .test_select_pin, .reset_pin_n, .shared_select_pin, .shared_clock_pin,
    .shared_serial_in_pin, .shared_serial_out_pin, .shared_serial_out_pin_oe_n, .host_select_n, .host_clock,
    .host_serial_in, .host_serial_out, .host_serial_out_en, .scan_mode_select, .scan_clock, .scan_data_in,
    .scan_data_out, .scan_data_out_en, .scan_reset_n, .feature_enable, .low_latency_mode, .functional_reset_n,
    .core_data, .core_status, .core_error_n, .data_out, .data_out_oe_n, .status_out, .error_out_n);

  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  // sampled at the falling edge: inputs only move at rising edges, so this is the value the next edge sees
  task automatic await(input int k);
    int n;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      if ((k == 0) ? s_axi_arready : (k == 1) ? s_axi_rvalid : s_axi_bvalid) break;
      @(posedge aclk);
    end
    if (n == 50) begin
      n_errors++;
      $display("MISMATCH bus_wait expected answer seen none");
      complete_run();
    end
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, ta, tw;
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    for (n = 0; n < 50 && !(aw && w); n++) begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      aw = aw | ta;
      w = w | tw;
    end
    await(2);
    ta = s_axi_bresp[0];
    tw = s_axi_bresp[1];
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, tw, ta});
  endtask

  task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    await(0);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    await(1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk("rdata", ed, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  // pins cross the board register and the synchroniser, so allow well over four edges
  task automatic settle;
    repeat (6) @(posedge aclk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    chk("low_latency", 1, low_latency_mode);
    chk("feature_enable", 0, feature_enable);
    axi_read(`MODE_STATUS_OFFSET, 32'hC, `RESP_OKAY);
    want_proc <= 1'b1;
    core_data <= 10'h2A5;
    settle();
    chk("feature_enable", 5'h1F, feature_enable);
    chk("low_latency", 0, low_latency_mode);
    chk("data_out", 10'h2A5, data_out);
    chk("data_out_oe_n", 0, data_out_oe_n);
    axi_read(`MODE_STATUS_OFFSET, 32'h5, `RESP_OKAY);
    // each feature turned off alone, with the enable pin held high
    for (i = 0; i < 5; i++) begin
      axi_write(`FEATURE_DISABLE_OFFSET, 32'h1 << i, `RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("feature_enable", 5'h1F & ~(5'h1 << i), feature_enable);
      axi_read(`FEATURE_DISABLE_OFFSET, 32'h1 << i, `RESP_OKAY);
    end
    axi_read(4'h8, 32'h0, `RESP_DECERR);
    axi_write(4'hC, 32'h1F, `RESP_DECERR);
    axi_write(`MODE_STATUS_OFFSET, 32'h1F, `RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    axi_write(`FEATURE_DISABLE_OFFSET, 32'h3, `RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_read(`FEATURE_DISABLE_OFFSET, 32'h10, `RESP_OKAY);
    // host mode: shared pins reach the host port
    want_sel <= 1'b0;
    want_clk <= 1'b1;
    want_sdi <= 1'b1;
    host_serial_out <= 1'b1;
    host_serial_out_en <= 1'b1;
    settle();
    chk("host_select_n", 0, host_select_n);
    chk("host_clock", 1, host_clock);
    chk("host_serial_in", 1, host_serial_in);
    chk("scan_clock", 0, scan_clock);
    chk("shared_out", 1, shared_serial_out_pin);
    chk("shared_oe_n", 0, shared_serial_out_pin_oe_n);
    // test mode: the same pins reach the scan port
    want_test <= 1'b1;
    want_sel <= 1'b1;
    scan_data_out_en <= 1'b1;
    settle();
    chk("scan_mode_select", 1, scan_mode_select);
    chk("scan_clock", 1, scan_clock);
    chk("scan_data_in", 1, scan_data_in);
    chk("host_select_n", 1, host_select_n);
    chk("shared_out", 0, shared_serial_out_pin);
    chk("shared_oe_n", 0, shared_serial_out_pin_oe_n);
    want_rst_n <= 1'b0;
    settle();
    chk("scan_reset_n", 0, scan_reset_n);
    chk("functional_reset_n", 0, functional_reset_n);
    want_rst_n <= 1'b1;
    settle();
    chk("scan_reset_n", 1, scan_reset_n);
    axi_read(`FEATURE_DISABLE_OFFSET, 32'h0, `RESP_OKAY);
    // host-mode reset: outputs released, status frozen at its last value
    want_test <= 1'b0;
    axi_write(`FEATURE_DISABLE_OFFSET, 32'h3, `RESP_OKAY);
    core_status <= 4'hA;
    core_error_n <= 1'b0;
    settle();
    want_rst_n <= 1'b0;
    settle();
    core_status <= 4'h5;
    core_error_n <= 1'b1;
    settle();
    chk("status_out", 4'hA, status_out);
    chk("error_out_n", 0, error_out_n);
    chk("data_out_oe_n", 1, data_out_oe_n);
    chk("shared_oe_n", 1, shared_serial_out_pin_oe_n);
    chk("functional_reset_n", 0, functional_reset_n);
    axi_read(`MODE_STATUS_OFFSET, 32'h1, `RESP_OKAY);
    want_rst_n <= 1'b1;
    settle();
    axi_read(`FEATURE_DISABLE_OFFSET, 32'h0, `RESP_OKAY);
    chk("feature_enable", 5'h1F, feature_enable);
    chk("status_out", 4'h5, status_out);
    // the board keeps processing on while the buffer runs video
    want_proc <= 1'b0;
    buffer_video_mode <= 1'b1;
    settle();
    chk("low_latency", 0, low_latency_mode);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
